// ### rtl/sacc_pkg.sv
// shared constants and types for the sar converter control block
package sacc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_RESULT = 8'h08;
  localparam logic [7:0] OFF_COMPARE = 8'h0C;
  localparam logic [7:0] OFF_CONFIG = 8'h10;
  // primary_status_control fields
  localparam int C1_DONE = 7;
  localparam int C1_INT_EN = 6;
  localparam int C1_CONT = 5;
  localparam int C1_SEL_LSB = 0;
  // secondary control fields
  localparam int C2_ACTIVE = 7;
  localparam int C2_TRIG_SEL = 6;
  localparam int C2_CMP_EN = 5;
  localparam int C2_CMP_GTE = 4;
  // configuration fields
  localparam int CF_LOW_POWER = 7;
  localparam int CF_DIV_LSB = 5;
  localparam int CF_LONG_SMP = 4;
  localparam int CF_FMT_LSB = 2;
  localparam int CF_SRC_LSB = 0;
  // reset values
  localparam logic [4:0] SEL_RESET = 5'h1F;
  localparam logic [1:0] FMT_RESET = 2'h0;
  localparam logic [1:0] SRC_RESET = 2'h0;
  // input_select_field codes
  localparam logic [4:0] SEL_EXT_LAST = 5'h17;
  localparam logic [4:0] SEL_TEMP = 5'h1A;
  localparam logic [4:0] SEL_BANDGAP = 5'h1B;
  localparam logic [4:0] SEL_REF_HIGH = 5'h1D;
  localparam logic [4:0] SEL_REF_LOW = 5'h1E;
  localparam logic [4:0] SEL_OFF = 5'h1F;
  // clock sources
  localparam logic [1:0] SRC_BUS = 2'h0;
  localparam logic [1:0] SRC_BUS_HALF = 2'h1;
  localparam logic [1:0] SRC_ALT = 2'h2;
  localparam logic [1:0] SRC_ASYNC = 2'h3;
  // result widths
  localparam logic [1:0] FMT_8 = 2'h0;
  localparam logic [1:0] FMT_12 = 2'h1;
  localparam logic [1:0] FMT_10 = 2'h2;
  // sample length in conversion clock ticks, minus one
  localparam logic [4:0] SMP_SHORT = 5'h03;
  localparam logic [4:0] SMP_LONG = 5'h17;
  // successive approximation
  localparam int RES_W = 12;
  localparam logic [3:0] SAR_MSB = 4'hB;
  localparam logic [11:0] SAR_START = 12'h800;
  // asynchronous input indices
  localparam int AS_CMP = 0;
  localparam int AS_ASYNC_CLK = 1;
  localparam int AS_ALT_CLK = 2;
  localparam int AS_HW_TRIG = 3;
  localparam int AS_N = 4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_FINISH = 4'b1000
  } sacc_state_t;
endpackage : sacc_pkg

// ### rtl/sacc_core.sv
// sar converter control: channel decode, clock select, triggering, result and apb registers
//
// Behaviour
// [RULE1] codes 0 through 23 route external inputs 0 to 23 in order
// [RULE2] reserved codes still convert; their result is undefined
// [RULE3] select bits for inputs absent on this variant are reserved
// [RULE4] code 11010 connects the temperature sensor
// [RULE5] code 11011 connects the internal bandgap reference
// [RULE6] clock from bus, bus halved, local async clock or alternate input
// [RULE7] conversion clock is source divided by the clock divide field
// [RULE8] alternate clock keeps working in wait mode
// [RULE9] alternate clock never clocks conversions in either stop mode
// [RULE10] hardware trigger selected: counter overflow pulse starts a conversion
// [RULE11] hardware triggers accepted in run, wait and shallow stop
// [RULE12] trigger input taken asynchronously; selectable against software start
// [RULE13] twelve bit linear successive approximation per sample
// [RULE14] unsigned right-justified result of twelve, ten or eight bits
// [RULE15] single conversion returns to idle; continuous repeats until stopped
// [RULE16] completion sets the done flag and, if enabled, an interrupt
// [RULE17] optional compare less-than or greater-equal; flag only when true
// [RULE18] converter keeps running in wait and shallow stop; in shallow stop it runs only on the async clock source
// [RULE19] sample length and speed/power trade-off set by software
// [RULE20] software uses long sample and slow clock before temperature reads
// [RULE21] no deepest stop mode, so no behaviour for it
// [RULE22] select all ones powers converter off and stops continuous mode
// [RULE23] primary control write aborts and restarts unless select is all ones
// [RULE24] done flag clears on primary control write or result read
// [RULE25] trigger select: clear starts on write, set on hardware trigger
`timescale 1ns/1ps
module sacc_core
  import sacc_pkg::*;
(
  input wire logic core_clk_i, // 25 MHz bus clock
  input wire logic reset_n_i, // asynchronous, active low
  input wire logic ce_i, // freezes all state while low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [7:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic pready_o, // apb ready
  output logic [31:0] prdata_o, // apb read data
  output logic pslverr_o, // apb error, unmapped address
  input wire logic cmp_i, // analog comparator: input above dac level
  input wire logic async_clk_i, // local asynchronous conversion clock
  input wire logic alt_clk_i, // alternate clock input
  input wire logic hw_trigger_i, // counter overflow trigger, asynchronous
  input wire logic wait_mode_i, // processor in wait mode
  input wire logic shallow_stop_i, // shallow stop mode
  input wire logic deep_stop_i, // deep stop mode
  output logic irq_o, // conversion complete interrupt
  output logic [4:0] chan_sel_o, // analog mux select
  output logic ext_chan_en_o, // external input routed
  output logic temp_sel_o, // temperature sensor routed
  output logic bandgap_sel_o, // bandgap routed
  output logic conv_power_o, // converter powered
  output logic low_power_o, // slow, low power converter bias
  output logic conv_clk_o, // conversion clock
  output logic sample_o, // sampling stage closed
  output logic [11:0] dac_code_o // trial code for the comparator
);

  sacc_state_t state;
  logic done_flag, int_en, cont_en, trig_sel, cmp_en, cmp_gte;
  logic low_power, long_smp;
  logic [4:0] input_sel;
  logic [1:0] clk_div, fmt_sel, clk_src;
  logic [11:0] cmp_value, result_data, fmt_res, next_dac;
  logic [4:0] smp_cnt, smp_len;
  logic [3:0] bit_idx;
  logic [2:0] div_cnt, div_max;
  logic bus_half;
  logic src_tick, conv_tick, cmp_pass, done_set;
  logic [AS_N-1:0] async_in, sync1, sync2, sync3, level, rise;
  logic apb_acc, apb_done, addr_hit, wr_ctrl1, rd_result;
  logic [31:0] rd_mux;
  logic in_stop;

  // three-stage synchronisers; a level counts once stages two and three agree
  assign async_in = {hw_trigger_i, alt_clk_i, async_clk_i, cmp_i};
  genvar g;
  for (g = 0; g < AS_N; g++) begin : g_sync
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        sync1[g] <= 1'b0;
        sync2[g] <= 1'b0;
        sync3[g] <= 1'b0;
        level[g] <= 1'b0;
      end else if (ce_i) begin
        sync1[g] <= async_in[g];
        sync2[g] <= sync1[g];
        sync3[g] <= sync2[g];
        if (sync2[g] == sync3[g]) begin
          level[g] <= sync3[g];
        end
      end
    end
    assign rise[g] = (sync2[g] == sync3[g]) && sync3[g] && !level[g]; // [RULE12]
  end

  // apb slave, one wait state so that read data comes from a flop
  assign apb_acc = psel_i && penable_i;
  assign apb_done = apb_acc && pready_o;
  assign wr_ctrl1 = apb_done && pwrite_i && (paddr_i == OFF_CTRL1);
  assign rd_result = apb_done && !pwrite_i && (paddr_i == OFF_RESULT);

  always_comb begin
    rd_mux = 32'h0000_0000;
    addr_hit = 1'b1;
    unique case (paddr_i)
      OFF_CTRL1: rd_mux = {24'h000000, done_flag, int_en, cont_en, input_sel};
      OFF_CTRL2: rd_mux = {24'h000000, (state != ST_IDLE), trig_sel, cmp_en, cmp_gte, 4'h0};
      OFF_RESULT: rd_mux = {20'h00000, result_data};
      OFF_COMPARE: rd_mux = {20'h00000, cmp_value};
      OFF_CONFIG: rd_mux = {24'h000000, low_power, clk_div, long_smp, fmt_sel, clk_src};
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      if (apb_acc && !pready_o) begin
        pready_o <= 1'b1;
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
        pslverr_o <= !addr_hit;
      end else begin
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
      end
    end
  end

  // software registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_en <= 1'b0;
      cont_en <= 1'b0;
      input_sel <= SEL_RESET;
      trig_sel <= 1'b0;
      cmp_en <= 1'b0;
      cmp_gte <= 1'b0;
      cmp_value <= 12'h000;
      low_power <= 1'b0;
      clk_div <= 2'h0;
      long_smp <= 1'b0;
      fmt_sel <= FMT_RESET;
      clk_src <= SRC_RESET;
    end else if (ce_i && apb_done && pwrite_i) begin
      unique case (paddr_i)
        OFF_CTRL1: begin
          int_en <= pwdata_i[C1_INT_EN];
          cont_en <= pwdata_i[C1_CONT];
          input_sel <= pwdata_i[C1_SEL_LSB +: 5];
        end
        OFF_CTRL2: begin
          trig_sel <= pwdata_i[C2_TRIG_SEL]; // [RULE12] [RULE25]
          cmp_en <= pwdata_i[C2_CMP_EN];
          cmp_gte <= pwdata_i[C2_CMP_GTE];
        end
        OFF_COMPARE: cmp_value <= pwdata_i[RES_W-1:0];
        OFF_CONFIG: begin
          low_power <= pwdata_i[CF_LOW_POWER]; // [RULE19]
          clk_div <= pwdata_i[CF_DIV_LSB +: 2];
          long_smp <= pwdata_i[CF_LONG_SMP];
          fmt_sel <= pwdata_i[CF_FMT_LSB +: 2];
          clk_src <= pwdata_i[CF_SRC_LSB +: 2];
        end
        default: ;
      endcase
    end
  end

  // clock source select; in stop the bus clock halts and the alternate input is barred
  assign in_stop = shallow_stop_i || deep_stop_i;
  always_comb begin
    unique case (clk_src) // [RULE6]
      SRC_BUS: src_tick = !in_stop;
      SRC_BUS_HALF: src_tick = !in_stop && bus_half;
      SRC_ALT: src_tick = rise[AS_ALT_CLK] && !in_stop; // [RULE8] [RULE9]
      default: src_tick = rise[AS_ASYNC_CLK]; // [RULE18]
    endcase
  end

  always_comb begin
    unique case (clk_div)
      2'h0: div_max = 3'h0;
      2'h1: div_max = 3'h1;
      2'h2: div_max = 3'h3;
      default: div_max = 3'h7;
    endcase
  end

  assign conv_tick = src_tick && (div_cnt == div_max) && (state != ST_IDLE); // [RULE7]

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_half <= 1'b0;
      div_cnt <= 3'h0;
      conv_clk_o <= 1'b0;
    end else if (ce_i) begin
      bus_half <= !bus_half;
      if (state == ST_IDLE) begin
        div_cnt <= 3'h0;
      end else if (src_tick) begin
        div_cnt <= (div_cnt == div_max) ? 3'h0 : div_cnt + 3'h1; // [RULE7]
      end
      if (conv_tick) begin
        conv_clk_o <= !conv_clk_o;
      end
    end
  end

  // one successive approximation step: drop the trial bit if below, try the next
  always_comb begin
    next_dac = dac_code_o;
    if (!level[AS_CMP]) begin
      next_dac[bit_idx] = 1'b0;
    end
    if (bit_idx != 4'h0) begin
      next_dac[bit_idx - 4'h1] = 1'b1;
    end
  end

  assign smp_len = long_smp ? SMP_LONG : SMP_SHORT; // [RULE19]

  // conversion sequencer
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      smp_cnt <= 5'h00;
      bit_idx <= 4'h0;
      dac_code_o <= 12'h000;
    end else if (ce_i) begin
      if (deep_stop_i) begin
        state <= ST_IDLE; // [RULE21]
      end else if (wr_ctrl1) begin
        smp_cnt <= 5'h00;
        if (!trig_sel && (pwdata_i[C1_SEL_LSB +: 5] != SEL_OFF)) begin
          state <= ST_SAMPLE; // [RULE23] [RULE25]
        end else begin
          state <= ST_IDLE; // [RULE22] [RULE23]
        end
      end else begin
        unique case (state)
          ST_IDLE: begin
            if (trig_sel && rise[AS_HW_TRIG] && (input_sel != SEL_OFF)) begin
              state <= ST_SAMPLE; // [RULE10] [RULE11] [RULE25]
              smp_cnt <= 5'h00;
            end
          end
          ST_SAMPLE: begin
            if (conv_tick) begin
              if (smp_cnt == smp_len) begin
                state <= ST_CONVERT;
                bit_idx <= SAR_MSB; // [RULE13]
                dac_code_o <= SAR_START;
              end else begin
                smp_cnt <= smp_cnt + 5'h01;
              end
            end
          end
          ST_CONVERT: begin
            if (conv_tick) begin
              dac_code_o <= next_dac; // [RULE13]
              if (bit_idx == 4'h0) begin
                state <= ST_FINISH;
              end else begin
                bit_idx <= bit_idx - 4'h1;
              end
            end
          end
          ST_FINISH: begin
            smp_cnt <= 5'h00;
            if (cont_en && (input_sel != SEL_OFF)) begin
              state <= ST_SAMPLE; // [RULE15]
            end else begin
              state <= ST_IDLE; // [RULE15]
            end
          end
        endcase
      end
    end
  end

  // result formatting and automatic compare
  always_comb begin
    unique case (fmt_sel) // [RULE14]
      FMT_12: fmt_res = dac_code_o;
      FMT_10: fmt_res = {2'h0, dac_code_o[11:2]};
      default: fmt_res = {4'h0, dac_code_o[11:4]};
    endcase
  end

  assign cmp_pass = !cmp_en || (cmp_gte ? (fmt_res >= cmp_value) : (fmt_res < cmp_value));
  assign done_set = (state == ST_FINISH) && cmp_pass; // [RULE16] [RULE17]

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_data <= 12'h000;
      done_flag <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      if (done_set) begin
        result_data <= fmt_res; // [RULE2] [RULE14]
      end
      // a completion in the same cycle as a clear keeps the flag set
      if (done_set) begin
        done_flag <= 1'b1; // [RULE16]
      end else if (wr_ctrl1 || rd_result) begin
        done_flag <= 1'b0; // [RULE24]
      end
      irq_o <= done_flag && int_en; // [RULE16]
    end
  end

  // analog routing; reserved codes connect nothing but still convert
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chan_sel_o <= SEL_RESET;
      ext_chan_en_o <= 1'b0;
      temp_sel_o <= 1'b0;
      bandgap_sel_o <= 1'b0;
      conv_power_o <= 1'b0;
      low_power_o <= 1'b0;
      sample_o <= 1'b0;
    end else if (ce_i) begin
      chan_sel_o <= input_sel; // [RULE1]
      ext_chan_en_o <= (input_sel <= SEL_EXT_LAST); // [RULE1] [RULE3]
      temp_sel_o <= (input_sel == SEL_TEMP); // [RULE4]
      bandgap_sel_o <= (input_sel == SEL_BANDGAP); // [RULE5]
      // powered only while converting: powered off after each single conversion
      conv_power_o <= (state != ST_IDLE) && (input_sel != SEL_OFF); // [RULE22]
      low_power_o <= low_power; // [RULE19]
      sample_o <= (state == ST_SAMPLE);
    end
  end

  // checks
  sequence s_enter_convert;
    state == ST_SAMPLE ##1 state == ST_CONVERT;
  endsequence

  sequence s_last_step;
    ce_i && state == ST_CONVERT && conv_tick && bit_idx == 4'h0;
  endsequence

  property p_sar_start;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_enter_convert |-> (bit_idx == SAR_MSB) && (dac_code_o == SAR_START);
  endproperty
  a_sar_start: assert property (p_sar_start) else $error("sar did not start at msb"); // [RULE13]

  property p_sar_end;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_last_step |=> state == ST_FINISH;
  endproperty
  a_sar_end: assert property (p_sar_end) else $error("sar end not reached"); // [RULE13]

  property p_sw_start;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (ce_i && !deep_stop_i && wr_ctrl1 && !trig_sel && pwdata_i[4:0] != SEL_OFF)
        |=> state == ST_SAMPLE && smp_cnt == 5'h00;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("write did not restart"); // [RULE23]

  property p_off;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (ce_i && input_sel == SEL_OFF && state == ST_IDLE && !wr_ctrl1) |=> state == ST_IDLE ##1 !conv_power_o;
  endproperty
  a_off: assert property (p_off) else $error("converter runs with select off"); // [RULE22]

  property p_hw_start;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (ce_i && !deep_stop_i && !wr_ctrl1 && trig_sel && state == ST_IDLE
        && rise[AS_HW_TRIG] && input_sel != SEL_OFF) |=> state == ST_SAMPLE;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("hardware trigger ignored"); // [RULE10]

  property p_sw_idle;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (ce_i && !trig_sel && state == ST_IDLE && !wr_ctrl1) |=> state == ST_IDLE;
  endproperty
  a_sw_idle: assert property (p_sw_idle) else $error("start without trigger"); // [RULE25]

  property p_single;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (ce_i && !deep_stop_i && !wr_ctrl1 && state == ST_FINISH && !cont_en) |=> state == ST_IDLE;
  endproperty
  a_single: assert property (p_single) else $error("single mode did not stop"); // [RULE15]

  property p_done_irq;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (ce_i && done_set && int_en && !(apb_done && pwrite_i && paddr_i == OFF_CTRL1))
        |=> done_flag ##1 (irq_o || !$past(ce_i));
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done or interrupt missing"); // [RULE16]

  property p_done_clear;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (ce_i && (wr_ctrl1 || rd_result) && !done_set) |=> !done_flag;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag not cleared"); // [RULE24]

  property p_cmp_block;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (ce_i && state == ST_FINISH && cmp_en && !cmp_gte && fmt_res >= cmp_value
        && !done_flag) |=> !done_flag && $stable(result_data);
  endproperty
  a_cmp_block: assert property (p_cmp_block) else $error("compare false but flagged"); // [RULE17]

  property p_fmt8;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (ce_i && done_set && fmt_sel == FMT_8) |=> result_data[11:8] == 4'h0;
  endproperty
  a_fmt8: assert property (p_fmt8) else $error("eight bit result not justified"); // [RULE14]

  property p_alt_stop;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (clk_src == SRC_ALT && in_stop) |-> !src_tick;
  endproperty
  a_alt_stop: assert property (p_alt_stop) else $error("alternate clock used in stop"); // [RULE9]

endmodule : sacc_core

// ### dv/test_sacc_core.sv
// self-checking testbench for the sar converter control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fails++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module test_sacc_core;
  import sacc_pkg::*;
  logic core_clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic cmp_i = 1'b0, async_clk_i = 1'b0, alt_clk_i = 1'b0, hw_trigger_i = 1'b0;
  logic wait_mode_i = 1'b0, shallow_stop_i = 1'b0, deep_stop_i = 1'b0;
  logic pready_o, pslverr_o, irq_o, ext_chan_en_o, temp_sel_o, bandgap_sel_o;
  logic conv_power_o, low_power_o, conv_clk_o, sample_o;
  logic [31:0] prdata_o;
  logic [4:0] chan_sel_o;
  logic [11:0] dac_code_o;
  logic [11:0] vin = 12'h0;
  logic [2:0] src_cnt = 3'h0;
  logic [31:0] seed = 32'h82b6;
  logic [31:0] r;
  logic e, ok;
  logic [13:0] snap;
  int fails = 0, num_checks = 0, cyc = 0;

  sacc_core dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .cmp_i(cmp_i), .async_clk_i(async_clk_i), .alt_clk_i(alt_clk_i),
    .hw_trigger_i(hw_trigger_i), .wait_mode_i(wait_mode_i), .shallow_stop_i(shallow_stop_i),
    .deep_stop_i(deep_stop_i), .irq_o(irq_o), .chan_sel_o(chan_sel_o),
    .ext_chan_en_o(ext_chan_en_o), .temp_sel_o(temp_sel_o), .bandgap_sel_o(bandgap_sel_o),
    .conv_power_o(conv_power_o), .low_power_o(low_power_o), .conv_clk_o(conv_clk_o),
    .sample_o(sample_o), .dac_code_o(dac_code_o));

  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  // ideal analog input: comparator says input at or above the trial code
  always @(posedge core_clk_i) begin
    cmp_i <= (vin >= dac_code_o);
    src_cnt <= src_cnt + 3'h1;
    alt_clk_i <= src_cnt[2];
    async_clk_i <= src_cnt[2];
    cyc++;
    if (cyc == 60000) begin
      fails++;
      give_verdict();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [11:0] fmt_res(input int v, input logic [1:0] f);
    if (f == FMT_12) return 12'(v);
    if (f == FMT_10) return 12'(v >> 2);
    return 12'(v >> 4);
  endfunction : fmt_res

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, d, x, y);
  endtask : wr

  task automatic wait_done(input int lim, output logic got);
    logic y;
    got = 1'b0;
    for (int i = 0; i < lim && got == 1'b0; i++) begin
      apb(1'b0, OFF_CTRL1, 32'h0, r, y);
      got = r[C1_DONE];
    end
  endtask : wait_done

  // one conversion; c2 carries trigger and compare settings
  task automatic conv(input logic [7:0] cfg, input logic [4:0] sel, input logic [7:0] c2,
                      input logic [11:0] cv, input logic runs);
    logic exp_ok;
    logic [11:0] res;
    seed = lfsr(seed);
    vin <= seed[11:0];
    res = fmt_res(seed[11:0], cfg[3:2]);
    exp_ok = runs;
    if (c2[C2_CMP_EN]) exp_ok = runs && (c2[C2_CMP_GTE] ? res >= cv : res < cv);
    wr(OFF_CONFIG, {24'h0, cfg});
    wr(OFF_COMPARE, {20'h0, cv});
    wr(OFF_CTRL2, {24'h0, c2});
    wr(OFF_CTRL1, {27'h0, sel});
    if (c2[C2_TRIG_SEL]) begin
      repeat (6) @(posedge core_clk_i);
      apb(1'b0, OFF_CTRL2, 32'h0, r, e);
      `CHK("idle before trigger", 1'b0, r[C2_ACTIVE])
      hw_trigger_i <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      hw_trigger_i <= 1'b0;
    end
    wait_done(700, ok);
    `CHK("done", exp_ok, ok)
    if (exp_ok) begin
      apb(1'b0, OFF_RESULT, 32'h0, r, e);
      `CHK("result", {20'h0, res}, r)
      apb(1'b0, OFF_CTRL1, 32'h0, r, e);
      `CHK("done after read", 1'b0, r[C1_DONE])
      apb(1'b0, OFF_CTRL2, 32'h0, r, e);
      `CHK("back to idle", 1'b0, r[C2_ACTIVE])
    end
  endtask : conv

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (6) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    `CHK("chan_sel reset", SEL_RESET, chan_sel_o)
    apb(1'b0, OFF_CTRL1, 32'h0, r, e);
    `CHK("ctrl1 reset", 32'h1F, r)
    apb(1'b0, 8'h14, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    $display("test reset done");
    // every select code below all ones, reserved ones included, must still power the converter
    for (int c = 0; c < 31; c++) begin
      wr(OFF_CTRL1, 32'(c));
      repeat (3) @(posedge core_clk_i);
      `CHK("chan_sel", 5'(c), chan_sel_o)
      `CHK("ext_en", c <= 23, ext_chan_en_o)
      `CHK("temp", c == 26, temp_sel_o)
      `CHK("bandgap", c == 27, bandgap_sel_o)
      `CHK("power", 1'b1, conv_power_o)
      `CHK("sample", 1'b1, sample_o)
    end
    wr(OFF_CTRL1, 32'h1F);
    repeat (3) @(posedge core_clk_i);
    `CHK("power off", 1'b0, conv_power_o)
    $display("test decode done");
    // each source and each width; slow enough for the synced comparator
    conv(8'h60, 5'd3, 8'h00, 12'h0, 1'b1);
    conv(8'h45, 5'd4, 8'h00, 12'h0, 1'b1);
    conv(8'h2A, 5'd5, 8'h00, 12'h0, 1'b1);
    conv(8'h2F, 5'd6, 8'h00, 12'h0, 1'b1);
    conv(8'hF7, 5'd26, 8'h00, 12'h0, 1'b1);
    `CHK("low_power", 1'b1, low_power_o)
    $display("test sources done");
    wait_mode_i <= 1'b1;
    conv(8'h26, 5'd8, 8'h00, 12'h0, 1'b1);
    wait_mode_i <= 1'b0;
    shallow_stop_i <= 1'b1;
    conv(8'h26, 5'd9, 8'h00, 12'h0, 1'b0);
    conv(8'h27, 5'd9, 8'h00, 12'h0, 1'b1);
    conv(8'h27, 5'd10, 8'h40, 12'h0, 1'b1);
    shallow_stop_i <= 1'b0;
    conv(8'h64, 5'd11, 8'h40, 12'h0, 1'b1);
    $display("test modes done");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      conv(8'h64, 5'd12, {2'b00, 1'b1, i[0], 4'h0}, seed[11:0], 1'b1);
    end
    conv(8'h64, 5'd12, 8'h30, 12'h000, 1'b1);
    conv(8'h64, 5'd12, 8'h20, 12'h000, 1'b1);
    $display("test compare done");
    wr(OFF_CONFIG, 32'h64);
    wr(OFF_CTRL2, 32'h0);
    wr(OFF_CTRL1, 32'h67);
    wait_done(160, ok);
    repeat (2) @(posedge core_clk_i);
    `CHK("irq set", 1'b1, irq_o)
    apb(1'b0, OFF_RESULT, 32'h0, r, e);
    repeat (2) @(posedge core_clk_i);
    `CHK("irq clear", 1'b0, irq_o)
    wait_done(160, ok);
    `CHK("continuous again", 1'b1, ok)
    wr(OFF_CTRL1, 32'h1F);
    repeat (3) @(posedge core_clk_i);
    `CHK("cont stop power", 1'b0, conv_power_o)
    wait_done(60, ok);
    `CHK("no extra conv", 1'b0, ok)
    $display("test continuous done");
    wr(OFF_CTRL1, 32'h05);
    repeat (10) @(posedge core_clk_i);
    snap = {conv_clk_o, sample_o, dac_code_o};
    repeat (8) @(posedge core_clk_i);
    `CHK("conv clk toggle", ~snap[13], conv_clk_o)
    ce_i <= 1'b0;
    @(posedge core_clk_i);
    snap = {conv_clk_o, sample_o, dac_code_o};
    repeat (20) @(posedge core_clk_i);
    `CHK("ce freeze", snap, {conv_clk_o, sample_o, dac_code_o})
    ce_i <= 1'b1;
    deep_stop_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    apb(1'b0, OFF_CTRL2, 32'h0, r, e);
    `CHK("deep stop abort", 1'b0, r[C2_ACTIVE])
    deep_stop_i <= 1'b0;
    wait_done(60, ok);
    `CHK("deep stop no done", 1'b0, ok)
    $display("test deep stop done");
    give_verdict();
  end
endmodule : test_sacc_core
